/* File: verilog/cfg_header_pkg.sv */
// constants for the configuration header register bank
package cfg_header_pkg;
  // word offsets (byte addresses) inside the header
  localparam logic [11:0] OFS_IDENT = 12'h000;
  localparam logic [11:0] OFS_CMDSTAT = 12'h004;
  localparam logic [11:0] OFS_CLASSREV = 12'h008;
  localparam logic [11:0] OFS_HDRLAT = 12'h00c;
  localparam logic [11:0] OFS_MBASEL = 12'h010;
  // command/status bit positions
  localparam int PARERR_BIT = 31;
  localparam int SSE_BIT = 30;
  localparam int RMA_BIT = 29;
  localparam int RTA_BIT = 28;
  localparam int MDPE_BIT = 24;
  localparam int FBB_BIT = 23;
  localparam int M66_BIT = 21;
  localparam int CAP_BIT = 20;
  localparam int SERREN_BIT = 8;
  localparam int PERREN_BIT = 6;
  localparam int MSTREN_BIT = 2;
  localparam int MEMEN_BIT = 1;
  // fixed codes and reset values
  localparam logic [7:0] BASE_CLASS = 8'h06;
  localparam logic [7:0] SUB_CLASS = 8'h80;
  localparam logic [7:0] PROG_IF = 8'h00;
  localparam logic [7:0] HEADER_TYPE = 8'h00;
  localparam logic [7:0] LINE_SIZE_KEEP = 8'h08;
  localparam logic [7:0] LINE_SIZE_RST = 8'h00;
  localparam logic [7:0] LAT_RST_PCI = 8'h00;
  localparam logic [7:0] LAT_RST_PCIX = 8'h40;
  localparam int LAT_GRAIN = 8;
  localparam logic [1:0] MEM_TYPE_64 = 2'h2;
  localparam int BASE_LSB = 12;
endpackage

/* File: verilog/cfg_header_regs.sv */
// configuration header register bank, shared by config and window access
`timescale 1ns/1ns
module cfg_header_regs
  import cfg_header_pkg::*;
#(
  parameter logic [15:0] DEVICE_ID = 16'h0001, // arbitrary value
  parameter logic [15:0] VENDOR_ID = 16'hffe0, // arbitrary value
  parameter logic [7:0] REVISION = 8'h00 // arbitrary value
) (
  input wire logic mclk, // bus clock
  input wire logic rst, // synchronous reset, active high
  input wire logic pcixMode, // 1 when the bus runs in PCI-X mode
  input wire logic cfgSel, // config cycle access strobe
  input wire logic winSel, // register window access strobe
  input wire logic wrEn, // 1 write, 0 read
  input wire logic [11:0] addr, // byte offset of the word
  input wire logic [3:0] byteEn, // active high byte enables
  input wire logic [31:0] wrData, // write data
  input wire logic parityErrDet, // pulse: any parity error detected
  input wire logic dataParityErr, // pulse: data parity error detected
  input wire logic perrSeen, // pulse: PERR# observed asserted
  input wire logic wasMaster, // device was master of the transfer
  input wire logic sysErrDet, // pulse: system error detected
  input wire logic masterAbort, // pulse: own transaction master-aborted
  input wire logic specialCycle, // that transaction was a special cycle
  input wire logic targetAbort, // pulse: own transaction target-aborted
  input wire logic memHit, // memory access decoded to this device
  input wire logic ioHit, // io access decoded to this device
  output logic [31:0] rdData, // read data
  output logic rdValid, // pulse: read data valid
  output logic serrDrive, // drive SERR# active
  output logic perrDrive, // drive PERR# active
  output logic masterAllowed, // may start master transactions
  output logic memClaim, // claim the memory access
  output logic ioClaim, // claim io access, always 0
  output logic [7:0] latencyTimer, // latency timer value
  output logic [10:0] latencyClocks, // timer in clocks
  output logic [31:BASE_LSB] windowBase // window base address bits
);
  logic parErr_q, sse_q, rma_q, rta_q, mdpe_q;
  logic serrEn_q, perrEn_q, mstrEn_q, memEn_q;
  logic [7:0] lineSize_q, latTimer_q;
  logic [31:BASE_LSB] base_q;
  logic [31:0] rdData_q;
  logic rdValid_q, serr_q, perr_q, ioClaim_q, memClaim_q;
  logic [10:0] latClk_q;

  // byte-lane merge used by the latency timer and the upper two base lanes
  function automatic logic [7:0] laneMerge(input logic [7:0] old,
      input logic [7:0] nw, input logic en);
    laneMerge = en ? nw : old;
  endfunction

  // one storage, two access paths
  wire access = cfgSel | winSel;
  wire wrAcc = access & wrEn;
  wire hitCmd = (addr == OFS_CMDSTAT);
  wire hitHdr = (addr == OFS_HDRLAT);
  wire hitBase = (addr == OFS_MBASEL);
  wire wrCmd = wrAcc & hitCmd;
  wire wrHdr = wrAcc & hitHdr;
  wire wrBase = wrAcc & hitBase;
  // write-one-to-clear strobes, top byte lane only
  wire [31:24] w1c = (wrCmd & byteEn[3]) ? wrData[31:24] : 8'h00;

  // hardware set events; set wins over a simultaneous clear
  wire setParErr = parityErrDet;
  wire driveSerr = serrEn_q & sysErrDet;
  wire drivePerr = perrEn_q & dataParityErr;
  wire setRma = masterAbort & ~specialCycle;
  wire setMdpe = (drivePerr | perrSeen) & wasMaster & perrEn_q;

  // assembled read words
  wire [31:0] wordIdent = {DEVICE_ID, VENDOR_ID};
  wire [31:0] wordCmd = {parErr_q, sse_q, rma_q, rta_q, 1'b0, 2'b00, mdpe_q,
      ~pcixMode, 1'b0, 1'b1, 1'b1, 11'h000, serrEn_q, 1'b0, perrEn_q,
      3'h0, mstrEn_q, memEn_q, 1'b0};
  wire [31:0] wordClass = {BASE_CLASS, SUB_CLASS, PROG_IF, REVISION};
  wire [31:0] wordHdr = {8'h00, HEADER_TYPE, latTimer_q, lineSize_q};
  wire [31:0] wordBase = {base_q, 8'h00, 1'b0, MEM_TYPE_64, 1'b0};

  // address decode of read data; unmapped offsets read zero
  logic [31:0] rdMux;
  always_comb begin
    if (addr == OFS_IDENT) begin
      rdMux = wordIdent;
    end else if (hitCmd) begin
      rdMux = wordCmd;
    end else if (addr == OFS_CLASSREV) begin
      rdMux = wordClass;
    end else if (hitHdr) begin
      rdMux = wordHdr;
    end else if (hitBase) begin
      rdMux = wordBase;
    end else begin
      rdMux = 32'h0000_0000;
    end
  end

  // cache line size: only 0x08 sticks
  // any other value collapses to zero rather than keeping the old one
  wire [7:0] lineSizeNew = (wrData[7:0] == LINE_SIZE_KEEP) ? LINE_SIZE_KEEP :
      LINE_SIZE_RST;

  // sticky status flags
  always_ff @(posedge mclk) begin
    if (rst) begin
      parErr_q <= 1'b0;
      sse_q <= 1'b0;
      rma_q <= 1'b0;
      rta_q <= 1'b0;
      mdpe_q <= 1'b0;
    end else begin
      parErr_q <= setParErr | (parErr_q & ~w1c[PARERR_BIT]);
      sse_q <= driveSerr | (sse_q & ~w1c[SSE_BIT]);
      rma_q <= setRma | (rma_q & ~w1c[RMA_BIT]);
      rta_q <= targetAbort | (rta_q & ~w1c[RTA_BIT]);
      mdpe_q <= setMdpe | (mdpe_q & ~w1c[MDPE_BIT]);
    end
  end

  // command enables, low two byte lanes
  always_ff @(posedge mclk) begin
    if (rst) begin
      serrEn_q <= 1'b0;
      perrEn_q <= 1'b0;
      mstrEn_q <= 1'b0;
      memEn_q <= 1'b0;
    end else begin
      if (wrCmd & byteEn[1]) begin
        serrEn_q <= wrData[SERREN_BIT];
      end
      if (wrCmd & byteEn[0]) begin
        perrEn_q <= wrData[PERREN_BIT];
        mstrEn_q <= wrData[MSTREN_BIT];
        memEn_q <= wrData[MEMEN_BIT];
      end
    end
  end

  // latency timer and cache line size; latency reset follows bus mode
  always_ff @(posedge mclk) begin
    if (rst) begin
      lineSize_q <= LINE_SIZE_RST;
      latTimer_q <= LAT_RST_PCI;
      if (pcixMode) begin
        latTimer_q <= LAT_RST_PCIX;
      end
    end else begin
      if (wrHdr & byteEn[0]) begin
        lineSize_q <= lineSizeNew;
      end
      latTimer_q <= laneMerge(latTimer_q, wrData[15:8], wrHdr & byteEn[1]);
    end
  end

  // window base address, bits 31:12 by lane
  always_ff @(posedge mclk) begin
    if (rst) begin
      base_q <= '0;
    end else if (wrBase) begin
      base_q[31:24] <= laneMerge(base_q[31:24], wrData[31:24], byteEn[3]);
      base_q[23:16] <= laneMerge(base_q[23:16], wrData[23:16], byteEn[2]);
      if (byteEn[1]) begin
        base_q[15:12] <= wrData[15:12];
      end
    end
  end

  // read return, pin drives and claims, all registered
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdData_q <= 32'h0000_0000;
      rdValid_q <= 1'b0;
      serr_q <= 1'b0;
      perr_q <= 1'b0;
      memClaim_q <= 1'b0;
      ioClaim_q <= 1'b0;
      latClk_q <= 11'h000;
    end else begin
      rdData_q <= (access & ~wrEn) ? rdMux : rdData_q;
      rdValid_q <= access & ~wrEn;
      serr_q <= driveSerr;
      perr_q <= drivePerr;
      memClaim_q <= memHit & memEn_q;
      // io enable is hard zero, so an io hit can never be claimed
      ioClaim_q <= ioHit & wordCmd[0];
      // granule of eight clocks per count, so multiply by shifting
      latClk_q <= {latTimer_q, 3'b000};
    end
  end

  assign rdData = rdData_q;
  assign rdValid = rdValid_q;
  assign serrDrive = serr_q;
  assign perrDrive = perr_q;
  assign masterAllowed = mstrEn_q;
  assign memClaim = memClaim_q;
  assign ioClaim = ioClaim_q;
  assign latencyTimer = latTimer_q;
  assign latencyClocks = latClk_q;
  assign windowBase = base_q;

  // checks
  chk_dpe_sets: assert property (@(posedge mclk) disable iff (rst)
    parityErrDet |=> parErr_q) else $error("parity flag not set");
  chk_sse_sets: assert property (@(posedge mclk) disable iff (rst)
    serr_q |-> sse_q) else $error("serr flag missing");
  chk_rma_special: assert property (@(posedge mclk) disable iff (rst)
    (masterAbort && !specialCycle) |=> rma_q)
    else $error("master abort flag missing");
  chk_rta_clear: assert property (@(posedge mclk) disable iff (rst)
    (rta_q && !targetAbort && w1c[RTA_BIT]) |=> !rta_q)
    else $error("target abort not cleared");
  chk_serr_gate: assert property (@(posedge mclk) disable iff (rst)
    serr_q |-> $past(serrEn_q)) else $error("serr without enable");
  chk_perr_gate: assert property (@(posedge mclk) disable iff (rst)
    perr_q |-> $past(perrEn_q)) else $error("perr without enable");
  chk_mem_gate: assert property (@(posedge mclk) disable iff (rst)
    memClaim_q |-> $past(memEn_q)) else $error("mem claim w/o enable");
  chk_io_never: assert property (@(posedge mclk) disable iff (rst)
    !ioClaim_q && !wordCmd[0]) else $error("io claimed");
  chk_cache_line_size_field_val: assert property (@(posedge mclk) disable iff (rst)
    lineSize_q == LINE_SIZE_RST || lineSize_q == LINE_SIZE_KEEP)
    else $error("bad cache line size");
  chk_base_low: assert property (@(posedge mclk) disable iff (rst)
    wordBase[11:0] == 12'h004) else $error("base low bits wrong");
  // the flag may only rise with parity response on and while mastering
  chk_mdpe_gate: assert property (@(posedge mclk) disable iff (rst)
    $rose(mdpe_q) |-> $past(perrEn_q && wasMaster))
    else $error("master parity flag ungated");
  chk_rta_sets: assert property (@(posedge mclk) disable iff (rst)
    targetAbort |=> rta_q) else $error("target abort flag missing");
  // clock count follows the timer one cycle later
  chk_lat_clocks: assert property (@(posedge mclk) disable iff (rst)
    !rst |=> latClk_q == {$past(latTimer_q), 3'h0})
    else $error("latency clocks wrong");
  // fixed status bits as returned on the read path
  chk_cmd_fixed: assert property (@(posedge mclk) disable iff (rst)
    (access && !wrEn && hitCmd) |=> rdData_q[27:25] == 3'h0 &&
    rdData_q[23:20] == {!$past(pcixMode), 3'h3})
    else $error("fixed status bits wrong");
  chk_ident_ro: assert property (@(posedge mclk) disable iff (rst)
    (access && !wrEn && addr == OFS_IDENT) |=>
    rdData_q == {DEVICE_ID, VENDOR_ID})
    else $error("identity word wrong");
  // a stored line size is the written value or zero, never anything else
  chk_cache_keep: assert property (@(posedge mclk) disable iff (rst)
    (wrHdr && byteEn[0]) |=> lineSize_q ==
    (($past(wrData[7:0]) == LINE_SIZE_KEEP) ? LINE_SIZE_KEEP : LINE_SIZE_RST))
    else $error("cache line size not kept");
  cov_serr: cover property (@(posedge mclk) serr_q ##1 sse_q);
  cov_clear: cover property (@(posedge mclk) parErr_q ##1 !parErr_q);
  cov_read: cover property (@(posedge mclk) rdValid_q && rdData_q != 0);
  cov_pcix_rst: cover property (@(posedge mclk)
    rst ##1 !rst && latTimer_q == LAT_RST_PCIX);
endmodule

/* File: tb/host_model.sv */
// host side model issuing config and window register cycles
`timescale 1ns/1ns
module host_model (
  input wire logic mclk, // bus clock
  output logic cfgSel, // config cycle strobe
  output logic winSel, // window cycle strobe
  output logic wrEn, // 1 write
  output logic [11:0] addr, // byte offset
  output logic [3:0] byteEn, // byte lanes
  output logic [31:0] wrData, // write data
  input wire logic [31:0] rdData, // read data
  input wire logic rdValid // read data valid pulse
);
  logic [31:0] rdBack; // last answer, unknown when none came

  // idle bus at time zero
  initial {cfgSel, winSel, wrEn, addr, byteEn, wrData} = '0;

  // one access, taken at the edge after launch; on release the strobes drop and
  // address and data are inverted so a stale value can never pass for a live one
  task xfer(input logic win, input logic wr, input logic [11:0] a,
            input logic [3:0] be, input logic [31:0] d);
    @(posedge mclk);
    cfgSel <= !win;
    winSel <= win;
    wrEn <= wr;
    addr <= a;
    byteEn <= be;
    wrData <= d;
    @(posedge mclk);
    cfgSel <= 1'b0;
    winSel <= 1'b0;
    addr <= ~a;
    wrData <= ~d;
    #1;
    rdBack = (rdValid === 1'b1) ? rdData : 'x;
  endtask
endmodule

/* File: tb/tb_top.sv */
// self-checking bench for the configuration header register bank
`timescale 1ns/1ns
module tb_top;
  import cfg_header_pkg::*;
  localparam logic [15:0] DevId = 16'h2a5c; // arbitrary value
  localparam logic [15:0] VenId = 16'hc3a5; // arbitrary value
  localparam logic [7:0] Rev = 8'h7e; // arbitrary value
  logic mclk, rst, pcixMode, cfgSel, winSel, wrEn, wasMaster, specialCycle;
  logic memHit, ioHit, rdValid, serrDrive, perrDrive, masterAllowed;
  logic memClaim, ioClaim, parityErrDet, dataParityErr, perrSeen;
  logic sysErrDet, masterAbort, targetAbort;
  logic [5:0] evs;
  logic [11:0] addr;
  logic [3:0] byteEn;
  logic [31:0] wrData, rdData;
  logic [7:0] latencyTimer;
  logic [10:0] latencyClocks;
  logic [31:BASE_LSB] windowBase;
  int errCount, checked, cyc;

  // event pulses travel as one vector
  assign {parityErrDet, dataParityErr, perrSeen, sysErrDet, masterAbort,
          targetAbort} = evs;

  cfg_header_regs #(.DEVICE_ID(DevId), .VENDOR_ID(VenId), .REVISION(Rev))
    dut (.mclk, .rst, .pcixMode, .cfgSel, .winSel, .wrEn, .addr, .byteEn,
    .wrData, .parityErrDet, .dataParityErr, .perrSeen, .wasMaster,
    .sysErrDet, .masterAbort, .specialCycle, .targetAbort, .memHit, .ioHit,
    .rdData, .rdValid, .serrDrive, .perrDrive, .masterAllowed, .memClaim,
    .ioClaim, .latencyTimer, .latencyClocks, .windowBase);
  host_model h (.mclk, .cfgSel, .winSel, .wrEn, .addr, .byteEn, .wrData,
    .rdData, .rdValid);

  // clock at 20 MHz
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task report_and_stop;
    $display("checks %0d errors %0d", checked, errCount);
    if (errCount == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // hang guard, far above the fewer than a hundred cycles the run needs
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      errCount++;
      report_and_stop;
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errCount++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task rdchk(input logic win, input logic [11:0] a, input logic [31:0] e);
    h.xfer(win, 1'b0, a, 4'h0, 32'h0);
    chk(h.rdBack, e);
  endtask
  task wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
    h.xfer(1'b0, 1'b1, a, be, d);
  endtask
  task do_reset(input logic px);
    @(posedge mclk);
    pcixMode <= px;
    rst <= 1'b1;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
  endtask
  // one event pulse; drive outputs are looked at in the following cycle
  task pulse(input logic [5:0] m, input logic [1:0] drv);
    @(posedge mclk);
    evs <= m;
    @(posedge mclk);
    evs <= '0;
    #1;
    chk({30'h0, serrDrive, perrDrive}, {30'h0, drv});
  endtask

  task t_reset_pci;
    do_reset(1'b0);
    rdchk(1'b0, OFS_IDENT, {DevId, VenId});
    @(posedge mclk) #1;
    chk({31'h0, rdValid}, 32'h0);
    rdchk(1'b1, OFS_CMDSTAT, 32'h00b00000);
    rdchk(1'b0, OFS_CLASSREV, {24'h068000, Rev});
    rdchk(1'b1, OFS_HDRLAT, 32'h0);
    rdchk(1'b0, OFS_MBASEL, 32'h4);
  endtask
  // all ones everywhere; only writable bits may keep them
  task t_write_all;
    for (int i = 0; i < 6; i++) wr(12'(i * 4), 4'hf, 32'hffffffff);
    rdchk(1'b1, OFS_IDENT, {DevId, VenId});
    rdchk(1'b1, OFS_CMDSTAT, 32'h00b00146);
    rdchk(1'b1, OFS_CLASSREV, {24'h068000, Rev});
    rdchk(1'b1, OFS_HDRLAT, 32'h0000ff00);
    rdchk(1'b0, OFS_MBASEL, 32'hfffff004);
    rdchk(1'b0, 12'h014, 32'h0);
    chk({21'h0, latencyClocks}, 32'h7f8);
    chk({windowBase, 12'h0}, 32'hfffff000);
    chk({31'h0, masterAllowed}, 32'h1);
    wr(OFS_HDRLAT, 4'h1, 32'h08);
    rdchk(1'b0, OFS_HDRLAT, 32'h0000ff08);
  endtask
  task t_events;
    pulse(6'b100000, 2'b00);
    pulse(6'b000100, 2'b10);
    @(posedge mclk) specialCycle <= 1'b1;
    pulse(6'b000010, 2'b00);
    pulse(6'b001000, 2'b00);
    rdchk(1'b0, OFS_CMDSTAT, 32'hc0b00146);
    @(posedge mclk) {specialCycle, wasMaster} <= 2'b01;
    pulse(6'b000010, 2'b00);
    pulse(6'b000001, 2'b00);
    pulse(6'b010000, 2'b01);
    rdchk(1'b1, OFS_CMDSTAT, 32'hf1b00146);
    wr(OFS_CMDSTAT, 4'h8, 32'h0);
    rdchk(1'b1, OFS_CMDSTAT, 32'hf1b00146);
    wr(OFS_CMDSTAT, 4'h8, 32'hff000000);
    rdchk(1'b0, OFS_CMDSTAT, 32'h00b00146);
  endtask
  task t_enables;
    @(posedge mclk) {memHit, ioHit} <= 2'b11;
    @(posedge mclk) #1;
    chk({30'h0, memClaim, ioClaim}, 32'h2);
    wr(OFS_CMDSTAT, 4'h3, 32'h0);
    @(posedge mclk) #1;
    chk({30'h0, memClaim, masterAllowed}, 32'h0);
    pulse(6'b010100, 2'b00);
    pulse(6'b100000, 2'b00);
    rdchk(1'b1, OFS_CMDSTAT, 32'h80b00000);
  endtask
  task t_reset_pcix;
    do_reset(1'b1);
    rdchk(1'b0, OFS_HDRLAT, 32'h00004000);
    rdchk(1'b1, OFS_CMDSTAT, 32'h00300000);
    chk({13'h0, latencyClocks, latencyTimer}, {13'h0, 11'h200, 8'h40});
  endtask

  // time-zero values, then the scenarios
  initial begin
    {rst, pcixMode, wasMaster, specialCycle, memHit, ioHit} = 6'b100000;
    evs = '0;
    t_reset_pci;
    t_write_all;
    t_events;
    t_enables;
    t_reset_pcix;
    report_and_stop;
  end
endmodule
